// ===== tb/boot_flash_section_guard_tb.sv
// Purpose: Self-checking bench for the boot flash section guard
// Assumes: Flash side is the behavioural macro model
// Notes:   Random locks and addresses from a fixed seed, fuse codes cycled by loop index
`timescale 1ns/1ps
`default_nettype none
`include "boot_guard_defines.vh"
module boot_flash_section_guard_tb;
  logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0, prog_lock_data = 4'hf, lk;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, load_data, cmd;
  logic        store_req = 1'b0, load_req = 1'b0, ivec_in_boot = 1'b0, slow = 1'b0;
  logic        chip_erase = 1'b0, prog_lock_wr = 1'b0, ok, den;
  logic [14:0] exec_addr = 15'h0000, store_addr = 15'h0000, bs, ex, tgt;
  logic [15:0] store_data = 16'h0000, load_addr = 16'h0000, la, flash_wdata, flash_rdata;
  logic [1:0]  boot_size_fuses = 2'h0;
  logic        load_done, load_denied, flash_done, flash_erase, flash_write;
  logic        flash_buf_load, flash_rd, cpu_halt, irq_suppress, section_busy_flag;
  logic [14:0] flash_addr, flash_rd_addr;
  logic [31:0] r;
  int          n_fail = 0, checked = 0, n_done = 0, nd;

  boot_flash_section_guard #(.AW(15)) dut (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_addr(exec_addr),
    .store_req(store_req), .store_addr(store_addr), .store_data(store_data),
    .load_req(load_req), .load_addr(load_addr), .load_data(load_data),
    .load_done(load_done), .load_denied(load_denied), .boot_size_fuses(boot_size_fuses),
    .ivec_in_boot(ivec_in_boot), .chip_erase(chip_erase), .prog_lock_wr(prog_lock_wr),
    .prog_lock_data(prog_lock_data), .flash_done(flash_done), .flash_rdata(flash_rdata),
    .flash_erase(flash_erase), .flash_write(flash_write), .flash_buf_load(flash_buf_load),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rd(flash_rd),
    .flash_rd_addr(flash_rd_addr), .cpu_halt(cpu_halt), .irq_suppress(irq_suppress),
    .section_busy_flag(section_busy_flag)
  );
  flash_macro_model u_flash (
    .mclk(mclk), .slow(slow), .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_rd(flash_rd), .flash_rd_addr(flash_rd_addr), .flash_done(flash_done),
    .flash_rdata(flash_rdata)
  );
  always #20 mclk = ~mclk;
  // Done pulses counted, since a short op can end while loads run
  always @(posedge mclk) if (flash_done === 1'b1) n_done <= n_done + 1;
  //////////////////////////////
  function automatic logic [14:0] boot_lo(input logic [1:0] f);
    boot_lo = (f == 2'h0) ? 15'h7000 : (f == 2'h1) ? 15'h7800 : (f == 2'h2) ? 15'h7c00 : 15'h7e00;
  endfunction
  function automatic logic [7:0] fbyte(input logic [15:0] a);
    fbyte = a[0] ? a[8:1] ^ 8'h5a : a[15:8];
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata & m, e);
  endtask
  task automatic st(input logic [14:0] e, input logic [14:0] a, input logic [15:0] d);
    @(posedge mclk);
    exec_addr <= e;
    store_addr <= a;
    store_data <= d;
    store_req <= 1'b1;
    @(posedge mclk);
    store_req <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic ld(input logic [14:0] e, input logic [15:0] a, input logic dn);
    @(posedge mclk);
    exec_addr <= e;
    load_addr <= a;
    load_req <= 1'b1;
    @(posedge mclk);
    load_req <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk({load_done, load_denied, load_data}, {1'b1, dn, dn ? `BLOCKED_BYTE : fbyte(a)});
  endtask
  task automatic plock(input logic [3:0] d);
    @(posedge mclk);
    prog_lock_data <= d;
    prog_lock_wr <= 1'b1;
    @(posedge mclk);
    prog_lock_wr <= 1'b0;
  endtask
  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    test_done;
  end
  initial begin
    r = $urandom(90543);
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`REG_CTRL, 8'h00, 8'hff);
    rd(`REG_LOCK, 8'h0f, 8'h0f);
    rd(4'h7, 8'h00, 8'hff);
    for (int i = 0; i < 48; i++) begin
      r = $urandom;
      lk = r[3:0];
      bs = boot_lo(i[1:0]);
      @(posedge mclk);
      boot_size_fuses <= i[1:0];
      ivec_in_boot <= r[4];
      slow <= r[5];
      chip_erase <= 1'b1;
      @(posedge mclk);
      chip_erase <= 1'b0;
      rd(`REG_BOOT_START, bs[14:7], 8'hff);
      if (i[2]) plock(lk);
      else begin
        wr(`REG_CTRL, 8'h09);
        st(15'h7fff, 15'h0000, {12'h000, lk});
      end
      plock(4'hf);
      rd(`REG_LOCK, {4'h0, lk}, 8'h0f);
      r = $urandom;
      case (r[1:0])
        2'h0: ex = bs - 15'h0001;
        2'h1: ex = bs;
        2'h2: ex = 15'h7fff - {6'h00, r[10:2]};
        default: ex = {1'b0, r[15:2]};
      endcase
      tgt = (i % 3 == 0) ? 15'h6fff + i[3] : r[30:16];
      cmd = r[31] ? 8'h03 : 8'h05;
      ok = ex >= bs && (tgt < bs ? lk[0] : lk[2]);
      nd = n_done;
      wr(`REG_CTRL, cmd);
      st(ex, tgt, 16'($urandom));
      chk({flash_erase, flash_write}, ok ? {cmd[1], cmd[2]} : 2'b00);
      if (ok) begin
        chk({flash_addr, cpu_halt, section_busy_flag}, {tgt, tgt >= 15'h7000, tgt < 15'h7000});
        if (tgt < 15'h7000) begin
          ld(15'h7fff, 16'hfe01, 1'b0);
          ld(15'h7fff, {tgt, 1'b0}, 1'b1);
        end else begin
          ld(15'h7fff, 16'hfe01, 1'b1);
        end
        for (int k = 0; k < 100 && n_done == nd; k++) @(negedge mclk);
        chk(24'(n_done - nd), 24'h000001);
        @(negedge mclk);
        chk({cpu_halt, section_busy_flag}, {1'b0, tgt < 15'h7000});
        // Clear busy before the next concurrent-section read
        wr(`REG_CTRL, r[17] ? 8'h11 : 8'h01);
        st(15'h7fff, 15'h0100, 16'h5a3c);
        chk({section_busy_flag, flash_buf_load}, {1'b0, !r[17]});
        if (!r[17]) chk(flash_wdata, 16'h5a3c);
      end
      r = $urandom;
      ex = r[0] ? 15'h7fff - {6'h00, r[9:1]} : {1'b0, r[23:10]};
      la = r[31:16];
      den = ex >= bs ? (la[15:1] < bs && !lk[1]) : (la[15:1] >= bs && !lk[3]);
      ld(ex, la, den);
      chk(irq_suppress, ivec_in_boot ? (ex < bs && !lk[1]) : (ex >= bs && !lk[3]));
    end
    test_done;
  end
endmodule // boot_flash_section_guard_tb
`default_nettype wire

// ===== tb/boot_guard_chk.sv
// Purpose: Port assertions for the boot flash section guard
// Assumes: Bound to the guard top, one clock, sync reset
// Notes:   Lock state is internal, so lock rules are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module boot_guard_chk #(
  parameter AW = 15
) (
  input wire logic          mclk,
  input wire logic          rst_b,
  input wire logic [AW-1:0] exec_addr,
  input wire logic          store_req,
  input wire logic          load_req,
  input wire logic [AW:0]   load_addr,
  input wire logic [7:0]    load_data,
  input wire logic          load_done,
  input wire logic          load_denied,
  input wire logic [1:0]    boot_size_fuses,
  input wire logic          flash_done,
  input wire logic          flash_erase,
  input wire logic          flash_write,
  input wire logic          flash_buf_load,
  input wire logic [AW-1:0] flash_addr,
  input wire logic          flash_rd,
  input wire logic          cpu_halt,
  input wire logic          section_busy_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [14:0] boot_lo;
  wire         op_go = flash_erase | flash_write;
  always_comb begin
    case (boot_size_fuses)
      2'h0: boot_lo = 15'h7000;
      2'h1: boot_lo = 15'h7800;
      2'h2: boot_lo = 15'h7c00;
      default: boot_lo = 15'h7e00;
    endcase
  end
  //////////////////////////////
  property p_app_store;
    store_req && exec_addr < boot_lo |=> !op_go && !flash_buf_load;
  endproperty
  a_app_store: assert property (p_app_store)
    else $error("store from application code acted");
  property p_stall_halt;
    op_go && flash_addr >= 15'h7000 |-> cpu_halt;
  endproperty
  a_stall_halt: assert property (p_stall_halt)
    else $error("stalling op without halt");
  property p_rww_busy;
    op_go && flash_addr < 15'h7000 |-> section_busy_flag && !cpu_halt;
  endproperty
  a_rww_busy: assert property (p_rww_busy)
    else $error("concurrent op without busy or with halt");
  property p_halt_hold;
    cpu_halt && !flash_done |=> cpu_halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halt dropped early");
  property p_halt_end;
    cpu_halt && flash_done |=> !cpu_halt;
  endproperty
  a_halt_end: assert property (p_halt_end)
    else $error("halt kept after done");
  property p_halt_no_rd;
    cpu_halt && $past(cpu_halt) |-> !flash_rd;
  endproperty
  a_halt_no_rd: assert property (p_halt_no_rd)
    else $error("flash read while halted");
  property p_busy_deny;
    section_busy_flag && load_req && !store_req && load_addr[AW:1] < 15'h7000
      |-> ##2 load_done && load_denied;
  endproperty
  a_busy_deny: assert property (p_busy_deny)
    else $error("busy section load not refused");
  property p_load_lat;
    load_req |-> ##2 load_done;
  endproperty
  a_load_lat: assert property (p_load_lat)
    else $error("load not answered in two cycles");
  property p_deny_data;
    load_denied |-> load_done && load_data == 8'hff && !$past(flash_rd);
  endproperty
  a_deny_data: assert property (p_deny_data)
    else $error("refused load had side effect or data");
  property p_busy_keep;
    section_busy_flag && !store_req |=> section_busy_flag;
  endproperty
  a_busy_keep: assert property (p_busy_keep)
    else $error("busy cleared without a store");
  c_rww: cover property (op_go && flash_addr < 15'h7000);
  c_stall: cover property (op_go && flash_addr >= 15'h7000);
  c_deny: cover property (load_denied);
  c_clear: cover property ($fell(section_busy_flag));
endmodule // boot_guard_chk

bind boot_flash_section_guard boot_guard_chk #(.AW(AW)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .exec_addr(exec_addr), .store_req(store_req),
  .load_req(load_req), .load_addr(load_addr), .load_data(load_data),
  .load_done(load_done), .load_denied(load_denied), .boot_size_fuses(boot_size_fuses),
  .flash_done(flash_done), .flash_erase(flash_erase), .flash_write(flash_write),
  .flash_buf_load(flash_buf_load), .flash_addr(flash_addr), .flash_rd(flash_rd),
  .cpu_halt(cpu_halt), .section_busy_flag(section_busy_flag)
);
`default_nettype wire

// ===== tb/flash_macro_model.sv
// Purpose: Behavioural flash macro facing the guard
// Assumes: Erase or write lasts 4 cycles, or 61 when slow is high
// Notes:   Read data scrambled outside read cycles, never held
`timescale 1ns/1ps
`default_nettype none
module flash_macro_model (
  input  wire logic        mclk,
  input  wire logic        slow,
  input  wire logic        flash_erase,
  input  wire logic        flash_write,
  input  wire logic        flash_rd,
  input  wire logic [14:0] flash_rd_addr,
  output wire logic        flash_done,
  output wire logic [15:0] flash_rdata
);
  logic [7:0]  busy_ff = 8'h00;
  logic        done_ff = 1'b0;
  logic [15:0] junk_ff = 16'h0000;
  always @(posedge mclk) begin
    junk_ff <= ~junk_ff ^ 16'h1234;
    done_ff <= busy_ff == 8'h01;
    if (flash_erase | flash_write) begin
      busy_ff <= slow ? 8'h3c : 8'h03;
    end else if (busy_ff != 8'h00) begin
      busy_ff <= busy_ff - 8'h01;
    end
  end
  assign flash_done  = done_ff;
  assign flash_rdata = flash_rd ? {flash_rd_addr[7:0] ^ 8'h5a, flash_rd_addr[14:7]} : junk_ff;
endmodule // flash_macro_model
`default_nettype wire

// ===== verilog/boot_flash_section_guard.v
// Purpose: Section access and protection for flash self-programming
// Assumes: Core gives one-cycle store/load requests; flash macro pulses done
// Notes:   Lock store reset models the erased state only
//
// Summary of operation
// - Store from application section is ignored, nothing programmed.
// - Store from boot section may program any flash page, boot included.
// - Boot section boundary follows the boot size fuse input.
// - Concurrent-section operation keeps core running, stalling section readable.
// - Stalling-section operation halts core and refuses flash reads until done.
// - Boot section always lies inside the stalling section.
// - Busy flag reads one while concurrent-section reads are blocked.
// - Lock bits only programmed by software or programmer; chip erase restores.
// - General write lock never blocks self-programming writes.
// - General read/write lock never restricts program-memory loads or stores.
// - Application lock mode 1 leaves application section unrestricted.
// - Application lock modes 2 and 3 block stores into application section.
// - Application lock modes 3 and 4 deny boot-code loads of application.
// - Those modes with boot vectors suppress interrupts in application code.
// - Boot lock modes 2 and 3 block stores into boot section.
// - Boot lock modes 3 and 4 deny application-code loads of boot section.
// - Busy flag set when concurrent-section erase or write starts.
// - Busy cleared by re-enable store after completion, or page load.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "boot_guard_defines.vh"

module boot_flash_section_guard #(
  parameter AW = 15
) (
  input  wire          mclk,
  input  wire          rst_b,
  input  wire [3:0]    reg_addr,
  input  wire [7:0]    reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [7:0]    reg_rdata,
  input  wire [AW-1:0] exec_addr,
  input  wire          store_req,
  input  wire [AW-1:0] store_addr,
  input  wire [15:0]   store_data,
  input  wire          load_req,
  input  wire [AW:0]   load_addr,
  output reg  [7:0]    load_data,
  output reg           load_done,
  output reg           load_denied,
  input  wire [1:0]    boot_size_fuses,
  input  wire          ivec_in_boot,
  input  wire          chip_erase,
  input  wire          prog_lock_wr,
  input  wire [3:0]    prog_lock_data,
  input  wire          flash_done,
  input  wire [15:0]   flash_rdata,
  output reg           flash_erase,
  output reg           flash_write,
  output reg           flash_buf_load,
  output reg  [AW-1:0] flash_addr,
  output reg  [15:0]   flash_wdata,
  output reg           flash_rd,
  output reg  [AW-1:0] flash_rd_addr,
  output reg           cpu_halt,
  output reg           irq_suppress,
  output reg           section_busy_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg  [4:0]    ctrl_ff;
  reg  [2:0]    arm_cnt_ff;
  reg  [3:0]    lock_ff;
  reg           busy_ff;
  reg           op_active_ff;
  reg           op_stall_ff;
  reg           ld_pend_ff;
  reg           ld_deny_ff;
  reg           ld_hi_ff;

  reg  [4:0]    nxt_ctrl;
  reg  [2:0]    nxt_arm_cnt;
  reg  [3:0]    nxt_lock;
  reg           nxt_busy;
  reg           nxt_op_active;
  reg           nxt_op_stall;
  reg           nxt_erase;
  reg           nxt_write;
  reg           nxt_buf_load;
  reg  [AW-1:0] nxt_flash_addr;
  reg  [15:0]   nxt_flash_wdata;
  reg  [7:0]    nxt_rdata;
  reg           nxt_ld_deny;

  ////////////////////////////////////////////////////////////////////////////
  // Section boundaries
  reg  [AW-1:0] boot_words;
  wire [AW-1:0] raw_boot_start;
  wire [AW-1:0] boot_start;
  wire [AW-1:0] stall_start;

  always @* begin
    case (boot_size_fuses)
      2'b00:   boot_words = `BOOT_WORDS_00;
      2'b01:   boot_words = `BOOT_WORDS_01;
      2'b10:   boot_words = `BOOT_WORDS_10;
      default: boot_words = `BOOT_WORDS_11;
    endcase
  end

  assign stall_start    = `STALL_START;
  assign raw_boot_start = {AW{1'b0}} - boot_words;
  assign boot_start     = (raw_boot_start < stall_start) ? stall_start : raw_boot_start;

  wire exec_boot;
  wire st_boot;
  wire st_stall;
  wire ld_boot;
  wire ld_stall;

  section_decode #(.AW(AW)) u_exec_dec (
    .addr        (exec_addr),
    .boot_start  (boot_start),
    .stall_start (stall_start),
    .in_boot     (exec_boot),
    // Execution side needs only the boot test
    .in_stall    ()
  );

  section_decode #(.AW(AW)) u_store_dec (
    .addr        (store_addr),
    .boot_start  (boot_start),
    .stall_start (stall_start),
    .in_boot     (st_boot),
    .in_stall    (st_stall)
  );

  section_decode #(.AW(AW)) u_load_dec (
    .addr        (load_addr[AW:1]),
    .boot_start  (boot_start),
    .stall_start (stall_start),
    .in_boot     (ld_boot),
    .in_stall    (ld_stall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protection decode
  wire app_wr_lock  = ~lock_ff[`LOCK_APP_LO];
  wire app_rd_lock  = ~lock_ff[`LOCK_APP_HI];
  wire boot_wr_lock = ~lock_ff[`LOCK_BOOT_LO];
  wire boot_rd_lock = ~lock_ff[`LOCK_BOOT_HI];

  wire st_locked = st_boot ? boot_wr_lock : app_wr_lock;

  wire armed      = (arm_cnt_ff != 3'h0);
  wire cmd_write  = (ctrl_ff == `CMD_WRITE);
  wire cmd_erase  = (ctrl_ff == `CMD_ERASE);
  wire cmd_buf    = (ctrl_ff == `CMD_BUFLOAD);
  wire cmd_lock   = (ctrl_ff == `CMD_LOCKSET);
  wire cmd_reen   = (ctrl_ff == `CMD_REEN);

  wire store_take = store_req & exec_boot & armed & ~op_active_ff;

  wire ld_lock_deny = (exec_boot & ~ld_boot & app_rd_lock) |
                      (~exec_boot & ld_boot & boot_rd_lock);
  wire ld_busy_deny = busy_ff & ~ld_stall;
  wire ld_halt_deny = op_active_ff & op_stall_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Command, lock and busy sequencing
  always @* begin
    nxt_ctrl        = ctrl_ff;
    nxt_arm_cnt     = arm_cnt_ff;
    nxt_lock        = lock_ff;
    nxt_busy        = busy_ff;
    nxt_op_active   = op_active_ff;
    nxt_op_stall    = op_stall_ff;
    nxt_erase       = 1'b0;
    nxt_write       = 1'b0;
    nxt_buf_load    = 1'b0;
    nxt_flash_addr  = flash_addr;
    nxt_flash_wdata = flash_wdata;

    if (op_active_ff) begin
      // Enable stays high until the macro reports completion
      if (flash_done) begin
        nxt_op_active = 1'b0;
        nxt_op_stall  = 1'b0;
        nxt_ctrl      = 5'h00;
        nxt_arm_cnt   = 3'h0;
      end
    end else if (store_take) begin
      nxt_ctrl    = 5'h00;
      nxt_arm_cnt = 3'h0;
      if (cmd_erase | cmd_write) begin
        if (!st_locked) begin
          nxt_erase      = cmd_erase;
          nxt_write      = cmd_write;
          nxt_flash_addr = store_addr;
          nxt_op_active  = 1'b1;
          nxt_op_stall   = st_stall;
          nxt_ctrl       = ctrl_ff;
          if (!st_stall) begin
            nxt_busy = 1'b1;
          end
        end
      end else if (cmd_buf) begin
        nxt_buf_load    = 1'b1;
        nxt_flash_addr  = store_addr;
        nxt_flash_wdata = store_data;
        nxt_busy        = 1'b0;
      end else if (cmd_lock) begin
        nxt_lock = lock_ff & store_data[3:0];
      end else if (cmd_reen) begin
        nxt_busy = 1'b0;
      end
    end else if (reg_wr && (reg_addr == `REG_CTRL)) begin
      case (reg_wdata[4:0])
        `CMD_REEN, `CMD_LOCKSET, `CMD_WRITE, `CMD_ERASE, `CMD_BUFLOAD: begin
          nxt_ctrl    = reg_wdata[4:0];
          nxt_arm_cnt = `ARM_CYCLES;
        end
        default: begin
          nxt_ctrl    = ctrl_ff;
          nxt_arm_cnt = arm_cnt_ff;
        end
      endcase
    end else if (armed) begin
      nxt_arm_cnt = arm_cnt_ff - 3'h1;
      if (arm_cnt_ff == 3'h1) begin
        nxt_ctrl = 5'h00;
      end
    end

    if (prog_lock_wr) begin
      nxt_lock = nxt_lock & prog_lock_data;
    end
    if (chip_erase) begin
      nxt_lock = `LOCK_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:       nxt_rdata = {1'b0, busy_ff, 1'b0, ctrl_ff};
        `REG_LOCK:       nxt_rdata = {4'h0, lock_ff};
        `REG_BOOT_START: nxt_rdata = boot_start[AW-1:AW-8];
        default:         nxt_rdata = 8'h00;
      endcase
    end
  end

  always @* begin
    nxt_ld_deny = ld_lock_deny | ld_busy_deny | ld_halt_deny;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flops
  always @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_ff           <= 5'h00;
      arm_cnt_ff        <= 3'h0;
      lock_ff           <= `LOCK_RESET;
      busy_ff           <= 1'b0;
      op_active_ff      <= 1'b0;
      op_stall_ff       <= 1'b0;
      flash_erase       <= 1'b0;
      flash_write       <= 1'b0;
      flash_buf_load    <= 1'b0;
      flash_addr        <= {AW{1'b0}};
      flash_wdata       <= 16'h0000;
      reg_rdata         <= 8'h00;
      cpu_halt          <= 1'b0;
      irq_suppress      <= 1'b0;
      section_busy_flag <= 1'b0;
    end else begin
      ctrl_ff           <= nxt_ctrl;
      arm_cnt_ff        <= nxt_arm_cnt;
      lock_ff           <= nxt_lock;
      busy_ff           <= nxt_busy;
      op_active_ff      <= nxt_op_active;
      op_stall_ff       <= nxt_op_stall;
      flash_erase       <= nxt_erase;
      flash_write       <= nxt_write;
      flash_buf_load    <= nxt_buf_load;
      flash_addr        <= nxt_flash_addr;
      flash_wdata       <= nxt_flash_wdata;
      reg_rdata         <= nxt_rdata;
      cpu_halt          <= nxt_op_active & nxt_op_stall;
      irq_suppress      <= (app_rd_lock & ivec_in_boot & ~exec_boot) |
                           (boot_rd_lock & ~ivec_in_boot & exec_boot);
      section_busy_flag <= nxt_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load path: request, flash read, answer
  always @(posedge mclk) begin
    if (!rst_b) begin
      ld_pend_ff    <= 1'b0;
      ld_deny_ff    <= 1'b0;
      ld_hi_ff      <= 1'b0;
      flash_rd      <= 1'b0;
      flash_rd_addr <= {AW{1'b0}};
      load_done     <= 1'b0;
      load_denied   <= 1'b0;
      load_data     <= 8'h00;
    end else begin
      ld_pend_ff  <= load_req;
      ld_deny_ff  <= nxt_ld_deny;
      ld_hi_ff    <= load_addr[0];
      flash_rd    <= load_req & ~nxt_ld_deny;
      if (load_req) begin
        flash_rd_addr <= load_addr[AW:1];
      end
      load_done   <= ld_pend_ff;
      load_denied <= ld_pend_ff & ld_deny_ff;
      if (ld_pend_ff) begin
        if (ld_deny_ff) begin
          load_data <= `BLOCKED_BYTE;
        end else if (ld_hi_ff) begin
          load_data <= flash_rdata[15:8];
        end else begin
          load_data <= flash_rdata[7:0];
        end
      end
    end
  end

endmodule // boot_flash_section_guard

`default_nettype wire

// ===== verilog/boot_guard_defines.vh
// Purpose: Shared constants of the boot flash section guard
// Assumes: Word-addressed flash, 8-bit register port
// Notes:   Included by bare name, definitions only
`ifndef BOOT_GUARD_DEFINES_VH
`define BOOT_GUARD_DEFINES_VH

// Register offsets
`define REG_CTRL        4'h0
`define REG_LOCK        4'h1
`define REG_BOOT_START  4'h2

// Control/status field positions
`define CTRL_EN         0
`define CTRL_ERASE      1
`define CTRL_WRITE      2
`define CTRL_LOCKSET    3
`define CTRL_REEN       4
`define CTRL_BUSY       6

// Accepted command patterns in the low five control bits
`define CMD_REEN        5'h11
`define CMD_LOCKSET     5'h09
`define CMD_WRITE       5'h05
`define CMD_ERASE       5'h03
`define CMD_BUFLOAD     5'h01

// Cycles a written command stays armed
`define ARM_CYCLES      3'h4

// Lock field positions and erased value (1 = unprogrammed)
`define LOCK_APP_LO     0
`define LOCK_APP_HI     1
`define LOCK_BOOT_LO    2
`define LOCK_BOOT_HI    3
`define LOCK_RESET      4'hf

// Byte returned by a refused load
`define BLOCKED_BYTE    8'hff

// Boot section sizes in words per fuse code
`define BOOT_WORDS_00   15'h1000
`define BOOT_WORDS_01   15'h0800
`define BOOT_WORDS_10   15'h0400
`define BOOT_WORDS_11   15'h0200

// First word of the stalling section
`define STALL_START     15'h7000

`endif

// ===== verilog/section_decode.v
// Purpose: Classify a flash word address into boot and stalling sections
// Assumes: Boot start and stalling start given as word addresses
// Notes:   Pure combinational helper
`timescale 1ns/1ps
`default_nettype none

module section_decode #(
  parameter AW = 15
) (
  input  wire [AW-1:0] addr,
  input  wire [AW-1:0] boot_start,
  input  wire [AW-1:0] stall_start,
  output wire          in_boot,
  output wire          in_stall
);

  assign in_boot  = (addr >= boot_start);
  assign in_stall = (addr >= stall_start);

endmodule // section_decode

`default_nettype wire
